//--- logic/lsu_pkg.sv
// Shared constants of the stack unload block: register map, fields, reset values
package lsu_pkg;

    // ------------------------------------------------------------------
    // Stack storage geometry
    // ------------------------------------------------------------------
    localparam int DATA_W      = 32;   // Long-word element width
    localparam int HALF_W      = 16;   // Word element width
    localparam int DEPTH       = 128;  // Elements of a word stack
    localparam int ADDR_W      = 7;    // Element address width
    localparam int BUS_AW      = 6;    // Byte address width of the slave

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_STATUS   = 4'h0;  // stack_status_word
    localparam logic [3:0] IDX_LENGTH   = 4'h1;  // stack_length_word
    localparam logic [3:0] IDX_POSITION = 4'h2;  // stack_position_word
    localparam logic [3:0] IDX_MODE     = 4'h3;  // Bit 0: long-word stack
    localparam logic [3:0] IDX_RUNG     = 4'h4;  // Bit 0 pop rung, bit 1 push rung
    localparam logic [3:0] IDX_SOURCE   = 4'h5;  // Value for the next push
    localparam logic [3:0] IDX_DEST     = 4'h6;  // Destination of the last pop
    localparam logic [3:0] IDX_IRQ_STAT = 4'h7;  // Sticky events, read only
    localparam logic [3:0] IDX_IRQ_CLR  = 4'h8;  // Write one to clear, write only
    localparam logic [3:0] IDX_IRQ_EN   = 4'h9;  // Event enables

    // ------------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------------
    localparam int BIT_POP_ENABLED = 14;  // pop_enabled_flag
    localparam int BIT_FULL        = 13;  // stack_full_flag
    localparam int BIT_EMPTY       = 12;  // stack_empty_flag
    localparam int BIT_RUNG_POP    = 0;
    localparam int BIT_RUNG_PUSH   = 1;

    // ------------------------------------------------------------------
    // Event bits
    // ------------------------------------------------------------------
    localparam int EV_POP_DONE  = 0;
    localparam int EV_POP_EMPTY = 1;
    localparam int EV_PUSH_DONE = 2;
    localparam int EV_PUSH_FULL = 3;
    localparam int EV_W         = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] LENGTH_RESET   = 16'h0001;
    localparam logic [15:0] POSITION_RESET = 16'h0000;
    localparam logic [3:0]  IRQ_EN_RESET   = 4'h0;

endpackage

//--- logic/lsu_mem_if.sv
// Carrier between the stack controller and its element memory
`timescale 1ns/1ps
`default_nettype none

interface lsu_mem_if;
    logic                          wr_en;
    logic                          rd_en;
    logic [lsu_pkg::ADDR_W-1:0]    addr;
    logic [lsu_pkg::DATA_W-1:0]    wdata;
    logic [lsu_pkg::DATA_W-1:0]    rdata;

    modport ctrl (output wr_en, output rd_en, output addr, output wdata, input rdata);
    modport mem  (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

//--- logic/lsu_stack_mem.sv
// Element memory of the stack with registered read data
`timescale 1ns/1ps
`default_nettype none

module lsu_stack_mem #(
    parameter int DEPTH = lsu_pkg::DEPTH
) (
    input  wire logic  SYS_CLK_IN,
    lsu_mem_if.mem     mif
);

    logic [lsu_pkg::DATA_W-1:0] cells [DEPTH];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Contents are never cleared by a read, so popped data stays in place
    always_ff @(posedge SYS_CLK_IN) begin
        if (mif.wr_en) begin
            cells[mif.addr] <= mif.wdata;
        end
        if (mif.rd_en) begin
            mif.rdata <= cells[mif.addr];
        end
    end

endmodule // lsu_stack_mem

`default_nettype wire

//--- logic/lsu_stack_unload.sv
// Last-in first-out stack with pop on rung edge, Avalon-MM register access
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module lsu_stack_unload #(
    parameter int DEPTH = lsu_pkg::DEPTH
) (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic [5:0]  ADDRESS_IN,
    input  wire logic        READ_IN,
    input  wire logic        WRITE_IN,
    input  wire logic [3:0]  BYTEENABLE_IN,
    input  wire logic [31:0] WRITEDATA_IN,
    output logic      [31:0] READDATA_OUT,
    output logic             WAITREQUEST_OUT,
    output logic             IRQ_OUT
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_POP  = 2'b10
    } lsu_state_t;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Merge a bus write into a register under the byte enables
    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Wrap a position into the range of the current element size by keeping its low bits
    function automatic logic [15:0] limit_pos(input logic [15:0] val,
                                              input logic        long_w);
        return long_w ? {10'h000, val[5:0]} : {9'h000, val[6:0]};
    endfunction

    // Fit a value to the element width of the current mode
    function automatic logic [31:0] fit_elem(input logic [31:0] val,
                                             input logic        long_w);
        return long_w ? val : {16'h0000, val[15:0]};
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    lsu_state_t                  state, next_state;
    logic [15:0]                 len, next_len;
    logic [15:0]                 pos, next_pos;
    logic                        long_mode, next_long_mode;
    logic                        rung_pop, next_rung_pop;
    logic                        rung_push, next_rung_push;
    logic                        rung_pop_q, next_rung_pop_q;
    logic                        rung_push_q, next_rung_push_q;
    logic                        pop_en, next_pop_en;
    logic [31:0]                 src, next_src;
    logic [31:0]                 dest, next_dest;
    logic [lsu_pkg::EV_W-1:0]    irq_stat, next_irq_stat;
    logic [lsu_pkg::EV_W-1:0]    irq_en, next_irq_en;
    logic                        irq, next_irq;
    logic                        waitreq, next_waitreq;
    logic [31:0]                 rdata, next_rdata;

    logic                        empty;
    logic                        full;
    logic                        pop_edge;
    logic                        push_edge;
    logic                        wr_take;
    logic [3:0]                  idx;
    logic [lsu_pkg::EV_W-1:0]    ev;
    logic [lsu_pkg::EV_W-1:0]    clr;
    logic [15:0]                 status_word;
    logic [31:0]                 len_merged;
    logic [31:0]                 pos_merged;

    lsu_mem_if mif ();

    lsu_stack_mem #(
        .DEPTH (DEPTH)
    ) u_mem (
        .SYS_CLK_IN (SYS_CLK_IN),
        .mif        (mif)
    );

    // ------------------------------------------------------------------
    // Flags and edges
    // ------------------------------------------------------------------
    // The position counts stored elements, so it is both fill level and pointer
    assign empty       = (pos == 16'h0000);
    assign full        = (pos >= len);
    assign pop_edge    = rung_pop && !rung_pop_q;
    assign push_edge   = rung_push && !rung_push_q;
    assign idx         = ADDRESS_IN[5:2];
    assign wr_take     = WRITE_IN && !waitreq;
    assign status_word = {1'b0, pop_en, full, empty, 12'h000};
    // Byte-lane merges of the 16-bit control words, cut to width where used
    assign len_merged  = merge_be({16'h0000, len}, WRITEDATA_IN, BYTEENABLE_IN);
    assign pos_merged  = merge_be({16'h0000, pos}, WRITEDATA_IN, BYTEENABLE_IN);

    // ------------------------------------------------------------------
    // Next-state logic: bus, stack control, events
    // ------------------------------------------------------------------
    always_comb begin
        next_state       = state;
        next_len         = len;
        next_pos         = pos;
        next_long_mode   = long_mode;
        next_rung_pop    = rung_pop;
        next_rung_push   = rung_push;
        next_rung_pop_q  = rung_pop_q;
        next_rung_push_q = rung_push_q;
        next_pop_en      = pop_en;
        next_src         = src;
        next_dest        = dest;
        next_irq_en      = irq_en;
        next_waitreq     = 1'b1;
        next_rdata       = rdata;
        ev               = '0;
        clr              = '0;
        mif.wr_en        = 1'b0;
        mif.rd_en        = 1'b0;
        mif.addr         = pos[lsu_pkg::ADDR_W-1:0];
        mif.wdata        = fit_elem(src, long_mode);

        // Read data is prepared one cycle ahead and answered with waitrequest low
        if (READ_IN && waitreq) begin
            next_waitreq = 1'b0;
            if (idx == lsu_pkg::IDX_STATUS) begin
                next_rdata = {16'h0000, status_word};
            end else if (idx == lsu_pkg::IDX_LENGTH) begin
                next_rdata = {16'h0000, len};
            end else if (idx == lsu_pkg::IDX_POSITION) begin
                next_rdata = {16'h0000, pos};
            end else if (idx == lsu_pkg::IDX_MODE) begin
                next_rdata = {31'h00000000, long_mode};
            end else if (idx == lsu_pkg::IDX_RUNG) begin
                next_rdata = {30'h00000000, rung_push, rung_pop};
            end else if (idx == lsu_pkg::IDX_SOURCE) begin
                next_rdata = src;
            end else if (idx == lsu_pkg::IDX_DEST) begin
                next_rdata = dest;
            end else if (idx == lsu_pkg::IDX_IRQ_STAT) begin
                next_rdata = {28'h0000000, irq_stat};
            end else if (idx == lsu_pkg::IDX_IRQ_EN) begin
                next_rdata = {28'h0000000, irq_en};
            end else begin
                next_rdata = 32'h00000000;  // Unmapped and write-only read zero
            end
        end else if (WRITE_IN && waitreq) begin
            next_waitreq = 1'b0;
        end

        // Writes take effect on the edge where waitrequest is seen low
        if (wr_take) begin
            if (idx == lsu_pkg::IDX_STATUS) begin
                if (BYTEENABLE_IN[1]) begin
                    next_pop_en = WRITEDATA_IN[lsu_pkg::BIT_POP_ENABLED];
                end
            end else if (idx == lsu_pkg::IDX_LENGTH) begin
                next_len = len_merged[15:0];
            end else if (idx == lsu_pkg::IDX_POSITION) begin
                next_pos = limit_pos(pos_merged[15:0], long_mode);
            end else if (idx == lsu_pkg::IDX_MODE) begin
                if (BYTEENABLE_IN[0]) begin
                    next_long_mode = WRITEDATA_IN[0];
                end
            end else if (idx == lsu_pkg::IDX_RUNG) begin
                if (BYTEENABLE_IN[0]) begin
                    next_rung_pop  = WRITEDATA_IN[lsu_pkg::BIT_RUNG_POP];
                    next_rung_push = WRITEDATA_IN[lsu_pkg::BIT_RUNG_PUSH];
                end
            end else if (idx == lsu_pkg::IDX_SOURCE) begin
                next_src = merge_be(src, WRITEDATA_IN, BYTEENABLE_IN);
            end else if (idx == lsu_pkg::IDX_IRQ_CLR) begin
                if (BYTEENABLE_IN[0]) begin
                    clr = WRITEDATA_IN[lsu_pkg::EV_W-1:0];
                end
            end else if (idx == lsu_pkg::IDX_IRQ_EN) begin
                if (BYTEENABLE_IN[0]) begin
                    next_irq_en = WRITEDATA_IN[lsu_pkg::EV_W-1:0];
                end
            end
        end

        // The enable flag follows the rung down; it rises on a pop edge or a status write while the rung is high
        if (!rung_pop) begin
            next_pop_en = 1'b0;
        end

        // Stack sequencing; a pop beats a push arriving in the same cycle
        case (state)
            ST_IDLE: begin
                // Edges are only consumed here, so none is lost while busy
                next_rung_pop_q  = rung_pop;
                next_rung_push_q = rung_push;
                if (pop_edge) begin
                    next_pop_en = 1'b1;
                    if (empty) begin
                        ev[lsu_pkg::EV_POP_EMPTY] = 1'b1;
                    end else begin
                        mif.rd_en  = 1'b1;
                        mif.addr   = 7'(pos - 16'h0001);
                        next_state = ST_POP;
                    end
                end else if (push_edge) begin
                    if (full) begin
                        ev[lsu_pkg::EV_PUSH_FULL] = 1'b1;
                    end else begin
                        mif.wr_en = 1'b1;
                        next_pos  = limit_pos(pos + 16'h0001, long_mode);
                        ev[lsu_pkg::EV_PUSH_DONE] = 1'b1;
                    end
                end
            end
            ST_POP: begin
                // Memory answered the read issued in the previous cycle
                next_dest  = fit_elem(mif.rdata, long_mode);
                next_pos   = pos - 16'h0001;
                next_state = ST_IDLE;
                ev[lsu_pkg::EV_POP_DONE] = 1'b1;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase

        // A new event wins over a clear in the same cycle
        next_irq_stat = (irq_stat & ~clr) | ev;
        next_irq      = |(next_irq_stat & next_irq_en);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            state       <= ST_IDLE;
            len         <= lsu_pkg::LENGTH_RESET;
            pos         <= lsu_pkg::POSITION_RESET;
            long_mode   <= 1'b0;
            rung_pop    <= 1'b0;
            rung_push   <= 1'b0;
            rung_pop_q  <= 1'b0;
            rung_push_q <= 1'b0;
            pop_en      <= 1'b0;
            src         <= 32'h00000000;
            dest        <= 32'h00000000;
            irq_stat    <= '0;
            irq_en      <= lsu_pkg::IRQ_EN_RESET;
            irq         <= 1'b0;
            waitreq     <= 1'b1;
            rdata       <= 32'h00000000;
        end else begin
            state       <= next_state;
            len         <= next_len;
            pos         <= next_pos;
            long_mode   <= next_long_mode;
            rung_pop    <= next_rung_pop;
            rung_push   <= next_rung_push;
            rung_pop_q  <= next_rung_pop_q;
            rung_push_q <= next_rung_push_q;
            pop_en      <= next_pop_en;
            src         <= next_src;
            dest        <= next_dest;
            irq_stat    <= next_irq_stat;
            irq_en      <= next_irq_en;
            irq         <= next_irq;
            waitreq     <= next_waitreq;
            rdata       <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    assign READDATA_OUT    = rdata;
    assign WAITREQUEST_OUT = waitreq;
    assign IRQ_OUT         = irq;

endmodule // lsu_stack_unload

`default_nettype wire

//--- verif/lsu_stack_unload_chk.sv
// Checker of bus timing, read-back fields and interrupt level of the stack block
`timescale 1ns/1ps
`default_nettype none

module lsu_unload_chk #(
    parameter int DEPTH = 128
) (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic [5:0]  ADDRESS_IN,
    input  wire logic        READ_IN,
    input  wire logic        WRITE_IN,
    input  wire logic [3:0]  BYTEENABLE_IN,
    input  wire logic [31:0] WRITEDATA_IN,
    input  wire logic [31:0] READDATA_OUT,
    input  wire logic        WAITREQUEST_OUT,
    input  wire logic        IRQ_OUT
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic       req;
    logic       rd_ans;
    logic [3:0] idx;
    logic [3:0] irq_en;
    logic [3:0] next_irq_en;

    // Request and answer qualifiers
    assign req    = READ_IN || WRITE_IN;
    assign rd_ans = READ_IN && !WAITREQUEST_OUT;
    assign idx    = ADDRESS_IN[5:2];

    // Shadow of the enable register, so the level output can be judged from the ports
    always_comb begin
        next_irq_en = irq_en;
        if (WRITE_IN && !WAITREQUEST_OUT && idx == lsu_pkg::IDX_IRQ_EN && BYTEENABLE_IN[0]) begin
            next_irq_en = WRITEDATA_IN[3:0];
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        irq_en <= RST_IN ? 4'h0 : next_irq_en;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);

    sequence s_start;
        req && WAITREQUEST_OUT;
    endsequence

    sequence s_answer;
        !WAITREQUEST_OUT ##1 WAITREQUEST_OUT;
    endsequence

    a_wait_answer: assert property (s_start |=> s_answer)
        else $error("request not answered after one wait cycle");
    a_wait_cause: assert property (!WAITREQUEST_OUT |-> $past(req))
        else $error("waitrequest low without a request");
    a_rdata_hold: assert property (!(READ_IN && WAITREQUEST_OUT) |=> $stable(READDATA_OUT))
        else $error("read data changed outside a read answer");
    a_ctrl_width: assert property (rd_ans && idx inside {4'h1, 4'h2} |-> READDATA_OUT[31:16] == 16'h0000)
        else $error("control word upper half not zero");
    a_pos_limit: assert property (rd_ans && idx == 4'h2 |-> READDATA_OUT[15:7] == 9'h000)
        else $error("position beyond word stack range");
    a_status_fields: assert property (rd_ans && idx == 4'h0 |-> (READDATA_OUT & 32'hFFFF8FFF) == 32'h0)
        else $error("status word has bits outside its flags");
    a_flags_excl: assert property (rd_ans && idx == 4'h0 |-> !(READDATA_OUT[13] && READDATA_OUT[12]))
        else $error("full and empty flags set together");
    a_unmapped_zero: assert property (rd_ans && idx > 4'h9 |-> READDATA_OUT == 32'h0)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (IRQ_OUT |-> irq_en != 4'h0)
        else $error("interrupt high with all events disabled");
endmodule // lsu_unload_chk

bind lsu_stack_unload lsu_unload_chk #(.DEPTH(DEPTH)) chk (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .ADDRESS_IN(ADDRESS_IN), .READ_IN(READ_IN),
    .WRITE_IN(WRITE_IN), .BYTEENABLE_IN(BYTEENABLE_IN), .WRITEDATA_IN(WRITEDATA_IN),
    .READDATA_OUT(READDATA_OUT), .WAITREQUEST_OUT(WAITREQUEST_OUT), .IRQ_OUT(IRQ_OUT));

`default_nettype wire

//--- verif/lsu_prog_model.sv
// Model of the controlling program: bus master that keeps the program's duties
`timescale 1ns/1ps
`default_nettype none

module lsu_prog_model (
    input  wire logic        clk_in,
    input  wire logic [31:0] rdata_in,
    input  wire logic        wait_in,
    output var  logic [5:0]  addr_out,
    output var  logic        read_out,
    output var  logic        write_out,
    output var  logic [3:0]  be_out,
    output var  logic [31:0] wdata_out
);
    // Idle bus from time zero
    initial begin
        addr_out  = 6'h00;
        read_out  = 1'b0;
        write_out = 1'b0;
        be_out    = 4'hF;
        wdata_out = 32'h0;
    end

    // Length the program may give: 1..128 word or 1..64 long word
    function automatic logic [31:0] legal_len(input logic long_w, input logic [31:0] n);
        return long_w ? (n % 32'd64) + 32'd1 : (n % 32'd128) + 32'd1;
    endfunction

    // One register access; the control words live in the register block only, and the
    // destination is always read as the full 32-bit word so widths match the stack
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_in);
        addr_out  <= {idx, 2'b00};
        wdata_out <= d;
        write_out <= wr;
        read_out  <= !wr;
        // Hold everything until waitrequest is sampled low; only the watchdog ends a hang
        do @(posedge clk_in); while (wait_in !== 1'b0);
        q = rdata_in;
        write_out <= 1'b0;
        read_out  <= 1'b0;
        wdata_out <= ~d;   // Released data must not look valid
    endtask
endmodule // lsu_prog_model

`default_nettype wire

//--- verif/tb.sv
// Self-checking testbench of the stack unload block
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        clk;
    logic        rst;
    logic [5:0]  addr;
    logic        rd_s;
    logic        wr_s;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        waitreq;
    logic        irq;
    int          num_errors;
    int          compares;
    logic [31:0] seed;
    logic [31:0] v[8];
    logic [31:0] len;

    // ------------------------------------------------------------------
    // Clock, partner and design
    // ------------------------------------------------------------------
    initial clk = 1'b0;
    always #50 clk = ~clk;

    lsu_prog_model prog (.clk_in(clk), .rdata_in(rdata), .wait_in(waitreq), .addr_out(addr),
        .read_out(rd_s), .write_out(wr_s), .be_out(be), .wdata_out(wdata));

    lsu_stack_unload uut (.SYS_CLK_IN(clk), .RST_IN(rst), .ADDRESS_IN(addr), .READ_IN(rd_s),
        .WRITE_IN(wr_s), .BYTEENABLE_IN(be), .WRITEDATA_IN(wdata), .READDATA_OUT(rdata),
        .WAITREQUEST_OUT(waitreq), .IRQ_OUT(irq));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        prog.bus(1'b0, idx, 32'h0, q);
        chk(q, exp);
    endtask

    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        logic [31:0] q;
        prog.bus(1'b1, idx, d, q);
    endtask

    // Rung write, then three cycles for the pop to land
    task automatic rung(input logic [31:0] r);
        wr(lsu_pkg::IDX_RUNG, r);
        repeat (3) @(posedge clk);
    endtask

    // Let the edge's updates land before looking at the level output
    task automatic chk_irq(input logic exp);
        #1;
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    // Push n random elements, watching the shared pointer climb
    task automatic fill(input int n);
        for (int i = 0; i < n; i++) begin
            v[i] = xs();
            wr(lsu_pkg::IDX_SOURCE, v[i]);
            rung(32'h2);
            rung(32'h0);
            rd(lsu_pkg::IDX_POSITION, i + 1);
        end
    endtask

    // Pop all n elements, last in first out, each raising the pop-done event
    task automatic drain(input int n, input logic [31:0] m);
        for (int i = n - 1; i >= 0; i--) begin
            rung(32'h1);
            rd(lsu_pkg::IDX_STATUS, (i == 0) ? 32'h5000 : 32'h4000);
            rung(32'h1);
            rd(lsu_pkg::IDX_POSITION, i);
            rd(lsu_pkg::IDX_DEST, v[i] & m);
            chk_irq(1'b1);
            wr(lsu_pkg::IDX_IRQ_CLR, 32'h1);
            chk_irq(1'b0);
            rung(32'h0);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the sequence takes
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        num_errors = 0;
        compares   = 0;
        seed       = 32'd79829;
        rst        = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(lsu_pkg::IDX_STATUS, 32'h1000);
        rd(lsu_pkg::IDX_LENGTH, 32'h1);
        rd(lsu_pkg::IDX_POSITION, 32'h0);
        wr(4'hC, 32'hFFFFFFFF);
        rd(4'hC, 32'h0);
        // Word stack of random small length, filled to full
        len = prog.legal_len(1'b0, xs() % 32'd6) + 32'd1;
        wr(lsu_pkg::IDX_LENGTH, len);
        wr(lsu_pkg::IDX_IRQ_EN, 32'h3);
        fill(int'(len));
        rd(lsu_pkg::IDX_STATUS, 32'h2000);
        rd(lsu_pkg::IDX_IRQ_STAT, 32'h4);
        chk_irq(1'b0);
        // Push on a full stack is refused: pointer stays, refusal event raised
        rung(32'h2);
        rung(32'h0);
        rd(lsu_pkg::IDX_POSITION, len);
        rd(lsu_pkg::IDX_IRQ_STAT, 32'hC);
        wr(lsu_pkg::IDX_IRQ_CLR, 32'h8);
        drain(int'(len), 32'h0000FFFF);
        // Pop on empty: nothing moves, refusal event raised
        rung(32'h1);
        rd(lsu_pkg::IDX_DEST, v[0] & 32'hFFFF);
        rd(lsu_pkg::IDX_POSITION, 32'h0);
        rd(lsu_pkg::IDX_STATUS, 32'h5000);
        // Software may drop the enable flag while the rung stays high
        wr(lsu_pkg::IDX_STATUS, 32'h0);
        rd(lsu_pkg::IDX_STATUS, 32'h1000);
        rd(lsu_pkg::IDX_IRQ_STAT, 32'h6);
        chk_irq(1'b1);
        wr(lsu_pkg::IDX_IRQ_CLR, 32'hF);
        rung(32'h0);
        // Masked event stays sticky but keeps the output low
        wr(lsu_pkg::IDX_IRQ_EN, 32'h0);
        rung(32'h1);
        rung(32'h0);
        rd(lsu_pkg::IDX_IRQ_STAT, 32'h2);
        chk_irq(1'b0);
        wr(lsu_pkg::IDX_IRQ_CLR, 32'hF);
        // Unloaded data is still in memory once the pointer is moved back
        wr(lsu_pkg::IDX_POSITION, len);
        rung(32'h1);
        rung(32'h0);
        rd(lsu_pkg::IDX_DEST, v[len - 1] & 32'hFFFF);
        // Position range in both element sizes
        wr(lsu_pkg::IDX_POSITION, 32'hFF);
        rd(lsu_pkg::IDX_POSITION, 32'h7F);
        wr(lsu_pkg::IDX_MODE, 32'h1);
        wr(lsu_pkg::IDX_POSITION, 32'hFF);
        rd(lsu_pkg::IDX_POSITION, 32'h3F);
        // Long-word stack, full 32-bit elements
        wr(lsu_pkg::IDX_POSITION, 32'h0);
        wr(lsu_pkg::IDX_LENGTH, 32'h2);
        wr(lsu_pkg::IDX_IRQ_EN, 32'h1);
        fill(2);
        rd(lsu_pkg::IDX_STATUS, 32'h2000);
        drain(2, 32'hFFFFFFFF);
        end_sim();
    end
endmodule // tb

`default_nettype wire
